// *** tb/key_matrix_scanner_test.sv ***
// self-checking bench for the key matrix scanner top
// assumes the matrix model on the sense pins and 50 ns clock
`default_nettype none

module key_matrix_scanner_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // signals
  // ************************************************************
  logic        core_clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        scan_req_in = 1'b0;
  logic        wake_fast_mode_in = 1'b0;
  logic        report_now_in = 1'b1;
  logic        valid_sense_level_in = 1'b0;
  logic        sleep_prep_in = 1'b0;
  logic        map_wr_en_in = 1'b0;
  logic [4:0]  map_wr_addr_in = 5'h00;
  logic [7:0]  map_wr_data_in = 8'h00;
  logic [29:0] pressed = 30'h0;
  logic [5:0]  sense_lines;
  logic [4:0]  drive_lines, drive_oe;
  logic        drive_ibuf_on, drive_wake_high, scan_done, update, pending;
  logic [5:0]  sense_ibuf_on;
  logic [7:0]  pressed_count, modifier;
  logic [47:0] key_codes;
  int          error_cnt = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          dur;
  logic        s_upd, s_pend, bad_drive;
  logic [7:0]  s_cnt;
  logic [47:0] s_codes, exp_codes = 48'h0;
  logic [31:0] seen_oe;

  always #25 core_clk_in = ~core_clk_in;

  kms_scanner u_kms_scanner (
    .core_clk_in          (core_clk_in),
    .reset_in             (reset_in),
    .scan_req_in          (scan_req_in),
    .wake_fast_mode_in    (wake_fast_mode_in),
    .report_now_in        (report_now_in),
    .valid_sense_level_in (valid_sense_level_in),
    .sleep_prep_in        (sleep_prep_in),
    .sense_lines_in       (sense_lines),
    .map_wr_en_in         (map_wr_en_in),
    .map_wr_addr_in       (map_wr_addr_in),
    .map_wr_data_in       (map_wr_data_in),
    .drive_lines_out      (drive_lines),
    .drive_oe_out         (drive_oe),
    .drive_ibuf_on_out    (drive_ibuf_on),
    .drive_wake_high_out  (drive_wake_high),
    .sense_ibuf_on_out    (sense_ibuf_on),
    .scan_done_out        (scan_done),
    .update_out           (update),
    .buffered_pending_out (pending),
    .pressed_count_out    (pressed_count),
    .modifier_out         (modifier),
    .key_codes_out        (key_codes)
  );

  kms_matrix_model u_kms_matrix_model (
    .drive_lines_in  (drive_lines),
    .drive_oe_in     (drive_oe),
    .pressed_in      (pressed),
    .sense_lines_out (sense_lines)
  );

  // ************************************************************
  // helpers
  // ************************************************************
  task automatic check(input string what, input logic [47:0] seen,
                       input logic [47:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop;
    $display("tests %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // ceiling well above the roughly 52000 cycles the tests need
  always @(posedge core_clk_in)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  // expected record: codes 8'h40 plus position, first six in scan order
  task automatic expect_record(input logic [29:0] p, output logic [7:0] n);
    n = 8'h00;
    for (int i = 0; i < 30; i++)
    begin
      if (p[i] && n < 8'h06)
      begin
        exp_codes[8*n +: 8] = 8'h40 + 8'(i);
        n++;
      end
    end
  endtask : expect_record

  task automatic do_scan(input logic fast, input logic rep, input bit poke);
    repeat (2) @(negedge core_clk_in);
    wake_fast_mode_in = fast;
    report_now_in = rep;
    scan_req_in = 1'b1;
    @(negedge core_clk_in);
    scan_req_in = 1'b0;
    dur = 0;
    seen_oe = 32'h0;
    bad_drive = 1'b0;
    while (scan_done !== 1'b1 && dur < 5000)
    begin
      @(negedge core_clk_in);
      dur++;
      seen_oe[drive_oe] = 1'b1;
      if (drive_lines !== 5'h00)
        bad_drive = 1'b1;
      scan_req_in = poke && (dur == 100);
    end
    s_upd = update;
    s_cnt = pressed_count;
    s_codes = key_codes;
    s_pend = pending;
    check("scan finished", 1'(dur < 5000), 1'b1);
    check("rows drive low", bad_drive, 1'b0);
    if (poke)
    begin
      repeat (450)
      begin
        @(negedge core_clk_in);
        check("no second done", scan_done, 1'b0);
      end
    end
  endtask : do_scan

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    check("count", pressed_count, 8'h00);
    check("sense ibuf", sense_ibuf_on, 6'h00);
    check("oe", drive_oe, 5'h00);
    for (int a = 0; a < 31; a++)
    begin
      @(negedge core_clk_in);
      map_wr_en_in = 1'b1;
      map_wr_addr_in = 5'(a);
      map_wr_data_in = (a < 30) ? 8'h40 + 8'(a) : 8'hE0;
    end
    @(negedge core_clk_in);
    map_wr_en_in = 1'b0;
    // release debounce starts empty: five released row passes first
    for (int k = 0; k < 5; k++)
    begin
      do_scan(1'b0, 1'b1, 1'b0);
      check("released row pass", 1'(dur > 2000), 1'b1);
      check("released no update", s_upd, 1'b0);
    end
    do_scan(1'b0, 1'b1, 1'b0);
    check("ibuf on", sense_ibuf_on, 6'h3F);
    check("idle no update", s_upd, 1'b0);
    check("early exit time", 1'(dur >= 395 && dur <= 420), 1'b1);
    check("only full check", seen_oe[31:1], 31'h40000000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_single;
    logic [7:0] n;
    pressed = 30'h0000_0100;
    expect_record(pressed, n);
    do_scan(1'b0, 1'b1, 1'b1);
    check("first scan filtered", s_upd, 1'b0);
    check("row pass patterns", seen_oe,
          32'h8001_0117);
    do_scan(1'b0, 1'b1, 1'b0);
    check("accepted", s_upd, 1'b1);
    check("count one", s_cnt, n);
    check("codes", s_codes, exp_codes);
    check("modifier", modifier, 8'h00);
    do_scan(1'b0, 1'b1, 1'b0);
    check("unchanged", s_upd, 1'b0);
    $display("test single done");
  endtask : t_single

  task automatic t_many;
    logic [7:0] n;
    pressed = 30'h2000_0C8D;
    expect_record(pressed, n);
    do_scan(1'b0, 1'b1, 1'b0);
    do_scan(1'b0, 1'b1, 1'b0);
    check("seven accepted", s_upd, 1'b1);
    check("count six", s_cnt, 8'h06);
    check("first six codes", s_codes, exp_codes);
    $display("test many done");
  endtask : t_many

  task automatic t_release;
    pressed = 30'h0;
    do_scan(1'b0, 1'b1, 1'b0);
    check("release filtered", s_upd, 1'b0);
    do_scan(1'b0, 1'b1, 1'b0);
    check("release accepted", s_upd, 1'b1);
    check("count zero", s_cnt, 8'h00);
    check("slots kept", s_codes, exp_codes);
    for (int k = 3; k <= 6; k++)
    begin
      do_scan(1'b0, 1'b1, 1'b0);
      check("no update", s_upd, 1'b0);
      check("exit on sixth", 1'(dur < 500), 1'(k == 6));
    end
    $display("test release done");
  endtask : t_release

  task automatic t_wake;
    logic [7:0] n;
    pressed = 30'h0800_0000;
    expect_record(pressed, n);
    do_scan(1'b1, 1'b1, 1'b0);
    check("fast accept", s_upd, 1'b1);
    check("fast count", s_cnt, n);
    check("fast codes", s_codes, exp_codes);
    // high level valid: every open column now reads as pressed
    valid_sense_level_in = 1'b1;
    pressed = 30'h0;
    expect_record(30'h3FFF_FFFF, n);
    do_scan(1'b0, 1'b1, 1'b0);
    check("high level filtered", s_upd, 1'b0);
    do_scan(1'b0, 1'b1, 1'b0);
    check("high level accepted", s_upd, 1'b1);
    check("high level count", s_cnt, n);
    check("high level codes", s_codes, exp_codes);
    valid_sense_level_in = 1'b0;
    $display("test wake done");
  endtask : t_wake

  task automatic t_buffer;
    logic [7:0] n;
    pressed = 30'h0000_0002;
    expect_record(pressed, n);
    do_scan(1'b0, 1'b0, 1'b0);
    do_scan(1'b0, 1'b0, 1'b0);
    check("held back", s_upd, 1'b0);
    check("pending", s_pend, 1'b1);
    do_scan(1'b0, 1'b1, 1'b0);
    check("buffer reported", s_upd, 1'b1);
    check("pending cleared", s_pend, 1'b0);
    check("buffered count", s_cnt, n);
    check("buffered codes", s_codes, exp_codes);
    $display("test buffer done");
  endtask : t_buffer

  task automatic t_sleep;
    @(negedge core_clk_in);
    check("no wake setup", drive_ibuf_on, 1'b0);
    sleep_prep_in = 1'b1;
    repeat (3) @(negedge core_clk_in);
    check("row ibuf", drive_ibuf_on, 1'b1);
    check("wake high", drive_wake_high, 1'b1);
    check("rows released", drive_oe, 5'h00);
    sleep_prep_in = 1'b0;
    $display("test sleep done");
  endtask : t_sleep

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    repeat (12) @(negedge core_clk_in);
    reset_in = 1'b0;
    t_reset();
    t_single();
    t_many();
    t_release();
    t_wake();
    t_buffer();
    t_sleep();
    report_and_stop();
  end

endmodule : key_matrix_scanner_test

`default_nettype wire

// *** tb/kms_matrix_model.sv ***
// passive key switch matrix: five rows by six columns, pull-ups on columns
// assumes the bench sets pressed_in; rows drive only while enabled
`default_nettype none

module kms_matrix_model (
  input  wire logic [4:0]  drive_lines_in,
  input  wire logic [4:0]  drive_oe_in,
  input  wire logic [29:0] pressed_in,
  output logic      [5:0]  sense_lines_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // column levels
  // ************************************************************
  // a column goes low only through a closed switch on a row driven low
  always_comb
  begin
    sense_lines_out = 6'h3F;
    for (int r = 0; r < 5; r++)
    begin
      for (int c = 0; c < 6; c++)
      begin
        if (drive_oe_in[r] && !drive_lines_in[r] && pressed_in[r*6+c])
          sense_lines_out[c] = 1'b0;
      end
    end
  end

endmodule : kms_matrix_model

`default_nettype wire

// *** verilog/kms_keymap_mem.sv ***
// key lookup table: one code per row/column crossing, row major
// assumes rd_addr is stable one cycle before rd_data is used
`default_nettype none

module kms_keymap_mem (
  input  wire logic core_clk_in,
  input  wire logic reset_in,
  kms_map_if.mem    map
);

  logic [kms_pkg::CODE_W-1:0] table_r [kms_pkg::NUM_KEYS];

  // ************************************************************
  // table storage, registered read
  // ************************************************************
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      for (int i = 0; i < kms_pkg::NUM_KEYS; i++)
      begin
        table_r[i] <= '0;
      end
    end
    else if (map.wr_en && (int'(map.wr_addr) < kms_pkg::NUM_KEYS))
    begin
      table_r[map.wr_addr] <= map.wr_data;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      map.rd_data <= '0;
    end
    else if (int'(map.rd_addr) < kms_pkg::NUM_KEYS)
    begin
      map.rd_data <= table_r[map.rd_addr];
    end
    else
    begin
      map.rd_data <= '0;
    end
  end

endmodule : kms_keymap_mem

`default_nettype wire

// *** verilog/kms_map_if.sv ***
// key map table access between scanner and its lookup memory
// assumes both ends run on the scanner clock
`default_nettype none

interface kms_map_if;
  logic                       wr_en;
  logic [kms_pkg::ADDR_W-1:0] wr_addr;
  logic [kms_pkg::CODE_W-1:0] wr_data;
  logic [kms_pkg::ADDR_W-1:0] rd_addr;
  logic [kms_pkg::CODE_W-1:0] rd_data;

  modport scanner (
    output wr_en,
    output wr_addr,
    output wr_data,
    output rd_addr,
    input  rd_data
  );

  modport mem (
    input  wr_en,
    input  wr_addr,
    input  wr_data,
    input  rd_addr,
    output rd_data
  );
endinterface : kms_map_if

`default_nettype wire

// *** verilog/kms_pkg.sv ***
// constants shared by the key matrix scanner and its key map memory
// assumes one 20 MHz clock and a synchronous active-high reset
//
// Summary of operation
// - serve five drive by six sense lines
// - idle sense lines read high, pulled up
// - drive rows low, low sense means pressed
// - active sense level is a configurable input
// - undriven row never registers a press
// - enable sense input buffers before sampling
// - before sleep, drive lines become wake inputs
// - update flag one on accepted change only
// - one full scan per scan request
// - accept change after two identical differing scans
// - reset: all released, filtering on
// - wake-fast mode bypasses filter, accepts immediately
// - report now, or hold record in buffer
// - record: count, modifier, six key codes
// - more than six keys: first six kept
// - codes come from table in matrix order
// - count cleared each scan, slots kept
// - count zero means release, slots invalid
// - full check first, exit if nothing active
// - wait settle time before sampling sense lines
// - stop after six successive all-released checks
`default_nettype none

package kms_pkg;

  // ************************************************************
  // matrix geometry and record layout
  // ************************************************************
  localparam int NUM_ROWS  = 5;
  localparam int NUM_COLS  = 6;
  localparam int NUM_KEYS  = NUM_ROWS * NUM_COLS;
  localparam int MAX_KEYS  = 6;
  localparam int CODE_W    = 8;
  localparam int REC_BYTES = 2 + MAX_KEYS;
  localparam int ADDR_W    = 5;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int SETTLE_NS     = 20000;
  // least time: round up to whole cycles
  localparam int SETTLE_CYC_I  =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0] SETTLE_CYC = 9'(SETTLE_CYC_I);
  localparam logic [2:0] RELEASE_CHECKS = 3'h6;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [NUM_KEYS-1:0] MATRIX_RST = 30'h0;
  localparam logic [7:0]          MODIFIER_RST = 8'h00;
  localparam logic [7:0]          COUNT_RST = 8'h00;

endpackage : kms_pkg

`default_nettype wire

// *** verilog/kms_scanner.sv ***
// key matrix scanner: settle, full check, row pass, filter, record
// assumes sense pins are asynchronous; all other inputs share the clock
`default_nettype none

module kms_scanner (
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  input  wire logic        scan_req_in,
  input  wire logic        wake_fast_mode_in,
  input  wire logic        report_now_in,
  input  wire logic        valid_sense_level_in,
  input  wire logic        sleep_prep_in,
  input  wire logic [5:0]  sense_lines_in,
  input  wire logic        map_wr_en_in,
  input  wire logic [4:0]  map_wr_addr_in,
  input  wire logic [7:0]  map_wr_data_in,
  output logic      [4:0]  drive_lines_out,
  output logic      [4:0]  drive_oe_out,
  output logic             drive_ibuf_on_out,
  output logic             drive_wake_high_out,
  output logic      [5:0]  sense_ibuf_on_out,
  output logic             scan_done_out,
  output logic             update_out,
  output logic             buffered_pending_out,
  output logic      [7:0]  pressed_count_out,
  output logic      [7:0]  modifier_out,
  output logic      [47:0] key_codes_out
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_FULL_SET, ST_FULL_CHK, ST_ROW_SET, ST_ROW_SMP,
    ST_FILTER, ST_BLD_ADDR, ST_BLD_WAIT, ST_BLD_DATA, ST_DONE
  } kms_state_e;

  kms_state_e  state_r;
  kms_state_e  state_nxt;
  logic [8:0]  wait_r;
  logic [2:0]  row_r;
  logic [2:0]  row_nxt;
  logic [2:0]  rel_cnt_r;
  logic [5:0]  sync1_r;
  logic [5:0]  sync2_r;
  logic [5:0]  active_w;
  logic [5:0]  need_r;
  logic [5:0]  cur_rows_r [kms_pkg::NUM_ROWS];
  logic [29:0] cur_w;
  logic [29:0] prev_r;
  logic [29:0] stored_r;
  logic        accept_w;
  logic        acc_r;
  logic [4:0]  idx_r;
  logic [4:0]  rd_addr_r;
  logic [7:0]  work_cnt_r;
  logic [47:0] work_codes_r;
  logic [7:0]  buf_cnt_r;
  logic [47:0] buf_codes_r;
  logic [4:0]  oe_nxt;
  logic        settled_w;

  kms_map_if map ();

  assign map.wr_en   = map_wr_en_in;
  assign map.wr_addr = map_wr_addr_in;
  assign map.wr_data = map_wr_data_in;
  assign map.rd_addr = rd_addr_r;

  kms_keymap_mem u_map (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .map         (map.mem)
  );

  // ************************************************************
  // sense pin synchroniser and level compare
  // ************************************************************
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      sync1_r <= 6'h3F;
      sync2_r <= 6'h3F;
    end
    else
    begin
      sync1_r <= sense_lines_in;
      sync2_r <= sync1_r;
    end
  end

  // pressed where the pin equals the configured level
  assign active_w = ~(sync2_r ^ {6{valid_sense_level_in}});

  // ************************************************************
  // sequencer
  // ************************************************************
  assign settled_w = (wait_r == kms_pkg::SETTLE_CYC - 9'h001);
  assign accept_w  = wake_fast_mode_in ? (cur_w != stored_r)
                   : ((cur_w == prev_r) && (cur_w != stored_r));

  always_comb
  begin
    state_nxt = state_r;
    row_nxt   = row_r;
    case (state_r)
      ST_IDLE:
        if (scan_req_in)
          state_nxt = ST_FULL_SET;
      ST_FULL_SET:
        if (settled_w)
          state_nxt = ST_FULL_CHK;
      ST_FULL_CHK:
      begin
        row_nxt = 3'h0;
        if ((active_w == 6'h00) &&
            (rel_cnt_r >= kms_pkg::RELEASE_CHECKS - 3'h1))
          state_nxt = ST_DONE;
        else
          state_nxt = ST_ROW_SET;
      end
      ST_ROW_SET:
        if (settled_w)
          state_nxt = ST_ROW_SMP;
      ST_ROW_SMP:
        if (row_r == 3'(kms_pkg::NUM_ROWS - 1))
          state_nxt = ST_FILTER;
        else
        begin
          state_nxt = ST_ROW_SET;
          row_nxt   = row_r + 3'h1;
        end
      ST_FILTER:
        state_nxt = accept_w ? ST_BLD_ADDR : ST_DONE;
      ST_BLD_ADDR:
        if ((idx_r == 5'(kms_pkg::NUM_KEYS)) ||
            (work_cnt_r == 8'(kms_pkg::MAX_KEYS)))
          state_nxt = ST_DONE;
        else if (stored_r[idx_r])
          state_nxt = ST_BLD_WAIT;
      ST_BLD_WAIT:
        state_nxt = ST_BLD_DATA;
      ST_BLD_DATA:
        state_nxt = ST_BLD_ADDR;
      ST_DONE:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      state_r <= ST_IDLE;
      row_r   <= 3'h0;
    end
    else
    begin
      state_r <= state_nxt;
      row_r   <= row_nxt;
    end
  end

  // settle counter restarts on every change of drive pattern
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in || settled_w ||
        ((state_r != ST_FULL_SET) && (state_r != ST_ROW_SET)))
      wait_r <= 9'h000;
    else
      wait_r <= wait_r + 9'h001;
  end

  // ************************************************************
  // pin control
  // ************************************************************
  always_comb
  begin
    oe_nxt = 5'h00;
    case (state_nxt)
      ST_FULL_SET, ST_FULL_CHK:
        oe_nxt = 5'h1F;
      ST_ROW_SET, ST_ROW_SMP:
        oe_nxt = 5'(5'h01 << row_nxt);
      default:
        oe_nxt = 5'h00;
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      drive_lines_out     <= 5'h00;
      drive_oe_out        <= 5'h00;
      drive_ibuf_on_out   <= 1'b0;
      drive_wake_high_out <= 1'b0;
    end
    else
    begin
      drive_lines_out     <= 5'h00;
      drive_oe_out        <= oe_nxt;
      // while asleep rows float as wake inputs, a press pulls them up
      drive_ibuf_on_out   <= (state_nxt == ST_IDLE) && sleep_prep_in;
      drive_wake_high_out <= (state_nxt == ST_IDLE) && sleep_prep_in;
    end
  end

  // buffers stay on once enabled; settle time covers their turn-on
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      sense_ibuf_on_out <= 6'h00;
    else if (scan_req_in)
      sense_ibuf_on_out <= 6'h3F;
  end

  // ************************************************************
  // full check, release debounce, row words
  // ************************************************************
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      need_r    <= 6'h00;
      rel_cnt_r <= 3'h0;
    end
    else if (state_r == ST_FULL_CHK)
    begin
      need_r <= active_w;
      if (active_w != 6'h00)
        rel_cnt_r <= 3'h0;
      else if (rel_cnt_r < kms_pkg::RELEASE_CHECKS)
        rel_cnt_r <= rel_cnt_r + 3'h1;
    end
  end

  for (genvar r = 0; r < kms_pkg::NUM_ROWS; r++)
  begin : g_row
    always_ff @(posedge core_clk_in)
    begin
      if (reset_in)
        cur_rows_r[r] <= 6'h00;
      else if ((state_r == ST_ROW_SMP) && (row_r == 3'(r)))
        cur_rows_r[r] <= active_w & need_r;
    end
    assign cur_w[r*kms_pkg::NUM_COLS +: kms_pkg::NUM_COLS] = cur_rows_r[r];
  end

  // ************************************************************
  // change filter
  // ************************************************************
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      prev_r   <= kms_pkg::MATRIX_RST;
      stored_r <= kms_pkg::MATRIX_RST;
      acc_r    <= 1'b0;
    end
    else if (state_r == ST_IDLE && scan_req_in)
      acc_r <= 1'b0;
    else if (state_r == ST_FILTER)
    begin
      prev_r <= cur_w;
      acc_r  <= accept_w;
      if (accept_w)
        stored_r <= cur_w;
    end
  end

  // ************************************************************
  // record build from the lookup table
  // ************************************************************
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      idx_r     <= 5'h00;
      rd_addr_r <= 5'h00;
    end
    else if (state_r == ST_FILTER)
      idx_r <= 5'h00;
    else if ((state_r == ST_BLD_ADDR) && (state_nxt != ST_DONE))
    begin
      rd_addr_r <= idx_r;
      idx_r     <= idx_r + 5'h01;
    end
  end

  // slots beyond the count keep stale codes
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      work_cnt_r   <= kms_pkg::COUNT_RST;
      work_codes_r <= 48'h0;
    end
    else if (state_r == ST_IDLE && scan_req_in)
      work_cnt_r <= kms_pkg::COUNT_RST;
    else if (state_r == ST_BLD_DATA)
    begin
      work_codes_r[work_cnt_r[2:0]*8 +: 8] <= map.rd_data;
      work_cnt_r <= work_cnt_r + 8'h01;
    end
  end

  // ************************************************************
  // reporting and buffered hold
  // ************************************************************
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      scan_done_out        <= 1'b0;
      update_out           <= 1'b0;
      buffered_pending_out <= 1'b0;
      pressed_count_out    <= kms_pkg::COUNT_RST;
      modifier_out         <= kms_pkg::MODIFIER_RST;
      key_codes_out        <= 48'h0;
      buf_cnt_r            <= kms_pkg::COUNT_RST;
      buf_codes_r          <= 48'h0;
    end
    else
    begin
      scan_done_out <= (state_r == ST_DONE);
      update_out    <= 1'b0;
      modifier_out  <= kms_pkg::MODIFIER_RST;
      if (state_r == ST_DONE)
      begin
        if (report_now_in && acc_r)
        begin
          update_out           <= 1'b1;
          buffered_pending_out <= 1'b0;
          pressed_count_out    <= work_cnt_r;
          key_codes_out        <= work_codes_r;
        end
        else if (report_now_in && buffered_pending_out)
        begin
          update_out           <= 1'b1;
          buffered_pending_out <= 1'b0;
          pressed_count_out    <= buf_cnt_r;
          key_codes_out        <= buf_codes_r;
        end
        else if (!report_now_in && acc_r)
        begin
          buffered_pending_out <= 1'b1;
          buf_cnt_r            <= work_cnt_r;
          buf_codes_r          <= work_codes_r;
        end
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);

  sequence seq_scan_start;
    (state_r == ST_IDLE) && scan_req_in;
  endsequence

  sequence seq_settling;
    (state_r == ST_FULL_SET && drive_oe_out == 5'h1F)[*8];
  endsequence

  AST_SETTLE_HOLD: assert property (
    seq_scan_start |=> seq_settling)
    else $error("sampling started before settle time");

  AST_OE_LOW: assert property (
    (drive_oe_out != 5'h00) |-> (drive_lines_out == 5'h00))
    else $error("driven row is not low");

  AST_ONE_ROW: assert property (
    (state_r == ST_ROW_SMP) |-> $onehot(drive_oe_out))
    else $error("row pass drives more than one row");

  AST_UPD_DONE: assert property (
    update_out |-> scan_done_out)
    else $error("update flag without done strobe");

  AST_MAX_SLOTS: assert property (
    pressed_count_out <= 8'(kms_pkg::MAX_KEYS))
    else $error("pressed count above six");

  AST_CNT_CLEAR: assert property (
    seq_scan_start |=> (work_cnt_r == 8'h00))
    else $error("pressed count not cleared at scan start");

  AST_FILTER_HOLD: assert property (
    (state_r == ST_FILTER && !wake_fast_mode_in && cur_w != prev_r)
    |=> $stable(stored_r))
    else $error("filter accepted unconfirmed state");

  AST_FAST_TAKE: assert property (
    (state_r == ST_FILTER && wake_fast_mode_in)
    |=> (stored_r == $past(cur_w)))
    else $error("wake-fast scan did not take sampled state");

  AST_IBUF_ON: assert property (
    (state_r == ST_FULL_CHK) |-> (sense_ibuf_on_out == 6'h3F))
    else $error("sampling with sense buffers off");

  AST_EARLY_EXIT: assert property (
    (state_r == ST_FULL_CHK && active_w == 6'h00 && rel_cnt_r >= 3'h5)
    |=> (state_r == ST_DONE) ##1 scan_done_out && !update_out)
    else $error("released matrix not ending scan at once");

  AST_HOLD_BUF: assert property (
    (state_r == ST_DONE && !report_now_in) |=> !update_out)
    else $error("buffered mode reported upward");

endmodule : kms_scanner

`default_nettype wire
